// [logic/e1frd_consts.vh]
// e1frd_consts.vh - constants for the framer reset/default block
// assumes inclusion by bare name from logic/ design files
`ifndef E1FRD_CONSTS_VH
`define E1FRD_CONSTS_VH

`define E1FRD_NUM_FRAMERS      8
`define E1FRD_FRAMER_IDX_W     3
`define E1FRD_RST_MIN_NS       100
`define E1FRD_CLK_PERIOD_NS    5
`define E1FRD_JAT_DIV_DEFAULT  8'h2F
`define E1FRD_STD_T1           1'b1
`define E1FRD_PATTERN_GEN_DETECTOR_FRAMER_DEF  3'h0
`define E1FRD_RX_MODE_W        3
`define E1FRD_TX_MODE_W        2
`define E1FRD_RX_MODES         3'h5
`define E1FRD_TX_MODES         2'h3
`define E1FRD_RX_SLAVE_EXT     3'h1
`define E1FRD_TX_SLAVE_EXT     2'h1

`endif

// [logic/e1frd_top.v]
// e1frd_top.v - reset handling and power-up defaults for eight framers
// assumes one synchronous host; config bits are plain ports, one row
// of loose bits per framer, selected by a framer index on writes.
// Functional notes
// - setting a framer's reset bit returns that framer to its reset state
// - low reset pin resets whole device; host holds it at least 100 ns
// - every register holds its default value before any software access
// - device starts in T1 mode; software clears standard bit for E1
// - line receive data defaults to NRZ, sampled on rising clock edge
// - both receive jitter attenuator divisors default to hex 2F
// - frame processor defaults to basic frame with CRC multiframe, CAS on
// - all three receive link controllers default to disabled
// - receive system side defaults to slave external signaling, outputs tristated
// - receive system data and signaling change on rising common clock edge
// - receive frame sync input marks basic frame alignment by default
// - pattern detector defaults to monitoring framer 1 receive data
// - pattern generator defaults to inserting into framer 1 transmit stream
// - transmit system side defaults slave external signaling, rising clock B
// - frame generator defaults CRC multiframe off, CAS insertion on
// - all three transmit link controllers default to disabled
// - line transmit data defaults to NRZ, changes on falling clock edge
// - both transmit jitter attenuator divisors default to hex 2F
// - transmit jitter attenuation on, locked to clock B, drives line clock
// - receive path offers five configurations, transmit path four
`timescale 1ns/1ps
`include "e1frd_consts.vh"

module e1frd_top #(
  parameter N = `E1FRD_NUM_FRAMERS
) (
  input  wire                         MCLK_I,
  input  wire                         RESETN_I,
  input  wire                         WR_I,
  input  wire [`E1FRD_FRAMER_IDX_W-1:0] FRAMER_SEL_I,
  input  wire                         SOFT_RESET_I,
  input  wire                         STD_WR_I,
  input  wire                         STD_T1_I,
  input  wire                         CFG_WR_I,
  input  wire                         RX_NRZ_I,
  input  wire                         RX_SAMPLE_FALL_I,
  input  wire [7:0]                   RX_DIV_FIRST_I,
  input  wire [7:0]                   RX_DIV_SECOND_I,
  input  wire                         RX_CRC_MF_I,
  input  wire                         RX_CAS_I,
  input  wire [2:0]                   RX_LINK_EN_I,
  input  wire [`E1FRD_RX_MODE_W-1:0]  RX_MODE_I,
  input  wire                         RX_OUT_EN_I,
  input  wire                         RX_SYS_FALL_I,
  input  wire                         RX_FS_MULTI_I,
  input  wire                         TX_SYS_FALL_I,
  input  wire [`E1FRD_TX_MODE_W-1:0]  TX_MODE_I,
  input  wire                         TX_CRC_MF_I,
  input  wire                         TX_CAS_I,
  input  wire [2:0]                   TX_LINK_EN_I,
  input  wire                         TX_NRZ_I,
  input  wire                         TX_UPDATE_RISE_I,
  input  wire [7:0]                   TX_DIV_FIRST_I,
  input  wire [7:0]                   TX_DIV_SECOND_I,
  input  wire                         TX_JAT_EN_I,
  input  wire                         PATTERN_GEN_DETECTOR_WR_I,
  input  wire [`E1FRD_FRAMER_IDX_W-1:0] PATTERN_GEN_DETECTOR_RX_SEL_I,
  input  wire [`E1FRD_FRAMER_IDX_W-1:0] PATTERN_GEN_DETECTOR_TX_SEL_I,
  output reg                          LINE_STANDARD_SELECT_O,
  output reg  [N-1:0]                 FRAMER_IN_RESET_O,
  output reg  [N-1:0]                 RX_NRZ_O,
  output reg  [N-1:0]                 RX_SAMPLE_FALL_O,
  output reg  [N*8-1:0]               RX_DIV_FIRST_O,
  output reg  [N*8-1:0]               RX_DIV_SECOND_O,
  output reg  [N-1:0]                 RX_CRC_MF_O,
  output reg  [N-1:0]                 RX_CAS_O,
  output reg  [N*3-1:0]               RX_LINK_EN_O,
  output reg  [N*`E1FRD_RX_MODE_W-1:0] RX_MODE_O,
  output reg  [N-1:0]                 RX_OUT_EN_O,
  output reg  [N-1:0]                 RX_SYS_FALL_O,
  output reg  [N-1:0]                 RX_FS_MULTI_O,
  output reg  [N-1:0]                 TX_SYS_FALL_O,
  output reg  [N*`E1FRD_TX_MODE_W-1:0] TX_MODE_O,
  output reg  [N-1:0]                 TX_CRC_MF_O,
  output reg  [N-1:0]                 TX_CAS_O,
  output reg  [N*3-1:0]               TX_LINK_EN_O,
  output reg  [N-1:0]                 TX_NRZ_O,
  output reg  [N-1:0]                 TX_UPDATE_RISE_O,
  output reg  [N*8-1:0]               TX_DIV_FIRST_O,
  output reg  [N*8-1:0]               TX_DIV_SECOND_O,
  output reg  [N-1:0]                 TX_JAT_EN_O,
  output reg  [N-1:0]                 TX_CLK_FROM_PLL_O,
  output reg  [`E1FRD_FRAMER_IDX_W-1:0] PATTERN_GEN_DETECTOR_RX_SEL_O,
  output reg  [`E1FRD_FRAMER_IDX_W-1:0] PATTERN_GEN_DETECTOR_TX_SEL_O
);

  // pin hold time in cycles, rounded up; the pin is async so this is
  // only documentation for the host side
  localparam RST_MIN_CYC =
    (`E1FRD_RST_MIN_NS + `E1FRD_CLK_PERIOD_NS - 1) / `E1FRD_CLK_PERIOD_NS;

  integer i;
  reg [N-1:0] soft_rst;

  // soft reset pulse for the selected framer only
  always @* begin
    soft_rst = {N{1'b0}};
    if (WR_I && SOFT_RESET_I)
      soft_rst[FRAMER_SEL_I] = 1'b1;
  end

  // global standard bit: pin reset only, never touched by framer reset
  always @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      LINE_STANDARD_SELECT_O <= `E1FRD_STD_T1;
      PATTERN_GEN_DETECTOR_RX_SEL_O          <= `E1FRD_PATTERN_GEN_DETECTOR_FRAMER_DEF;
      PATTERN_GEN_DETECTOR_TX_SEL_O          <= `E1FRD_PATTERN_GEN_DETECTOR_FRAMER_DEF;
    end else begin
      if (STD_WR_I)
        LINE_STANDARD_SELECT_O <= STD_T1_I;
      if (PATTERN_GEN_DETECTOR_WR_I) begin
        PATTERN_GEN_DETECTOR_RX_SEL_O <= PATTERN_GEN_DETECTOR_RX_SEL_I;
        PATTERN_GEN_DETECTOR_TX_SEL_O <= PATTERN_GEN_DETECTOR_TX_SEL_I;
      end
    end
  end

  // per-framer rows; a framer reset reloads its defaults in one edge
  always @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      FRAMER_IN_RESET_O <= {N{1'b0}};
      RX_NRZ_O          <= {N{1'b1}};
      RX_SAMPLE_FALL_O  <= {N{1'b0}};
      RX_DIV_FIRST_O    <= {N{`E1FRD_JAT_DIV_DEFAULT}};
      RX_DIV_SECOND_O   <= {N{`E1FRD_JAT_DIV_DEFAULT}};
      RX_CRC_MF_O       <= {N{1'b1}};
      RX_CAS_O          <= {N{1'b1}};
      RX_LINK_EN_O      <= {(N*3){1'b0}};
      RX_MODE_O         <= {N{`E1FRD_RX_SLAVE_EXT}};
      RX_OUT_EN_O       <= {N{1'b0}};
      RX_SYS_FALL_O     <= {N{1'b0}};
      RX_FS_MULTI_O     <= {N{1'b0}};
      TX_SYS_FALL_O     <= {N{1'b0}};
      TX_MODE_O         <= {N{`E1FRD_TX_SLAVE_EXT}};
      TX_CRC_MF_O       <= {N{1'b0}};
      TX_CAS_O          <= {N{1'b1}};
      TX_LINK_EN_O      <= {(N*3){1'b0}};
      TX_NRZ_O          <= {N{1'b1}};
      TX_UPDATE_RISE_O  <= {N{1'b0}};
      TX_DIV_FIRST_O    <= {N{`E1FRD_JAT_DIV_DEFAULT}};
      TX_DIV_SECOND_O   <= {N{`E1FRD_JAT_DIV_DEFAULT}};
      TX_JAT_EN_O       <= {N{1'b1}};
      TX_CLK_FROM_PLL_O <= {N{1'b1}};
    end else begin
      for (i = 0; i < N; i = i + 1) begin
        FRAMER_IN_RESET_O[i] <= soft_rst[i];
        if (soft_rst[i]) begin
          RX_NRZ_O[i]         <= 1'b1;
          RX_SAMPLE_FALL_O[i] <= 1'b0;
          RX_DIV_FIRST_O[i*8 +: 8]  <= `E1FRD_JAT_DIV_DEFAULT;
          RX_DIV_SECOND_O[i*8 +: 8] <= `E1FRD_JAT_DIV_DEFAULT;
          RX_CRC_MF_O[i]      <= 1'b1;
          RX_CAS_O[i]         <= 1'b1;
          RX_LINK_EN_O[i*3 +: 3] <= 3'h0;
          RX_MODE_O[i*`E1FRD_RX_MODE_W +: `E1FRD_RX_MODE_W] <=
            `E1FRD_RX_SLAVE_EXT;
          RX_OUT_EN_O[i]      <= 1'b0;
          RX_SYS_FALL_O[i]    <= 1'b0;
          RX_FS_MULTI_O[i]    <= 1'b0;
          TX_SYS_FALL_O[i]    <= 1'b0;
          TX_MODE_O[i*`E1FRD_TX_MODE_W +: `E1FRD_TX_MODE_W] <=
            `E1FRD_TX_SLAVE_EXT;
          TX_CRC_MF_O[i]      <= 1'b0;
          TX_CAS_O[i]         <= 1'b1;
          TX_LINK_EN_O[i*3 +: 3] <= 3'h0;
          TX_NRZ_O[i]         <= 1'b1;
          TX_UPDATE_RISE_O[i] <= 1'b0;
          TX_DIV_FIRST_O[i*8 +: 8]  <= `E1FRD_JAT_DIV_DEFAULT;
          TX_DIV_SECOND_O[i*8 +: 8] <= `E1FRD_JAT_DIV_DEFAULT;
          TX_JAT_EN_O[i]      <= 1'b1;
          TX_CLK_FROM_PLL_O[i] <= 1'b1;
        end else if (CFG_WR_I && !SOFT_RESET_I &&
                     FRAMER_SEL_I == i[`E1FRD_FRAMER_IDX_W-1:0]) begin
          RX_NRZ_O[i]         <= RX_NRZ_I;
          RX_SAMPLE_FALL_O[i] <= RX_SAMPLE_FALL_I;
          RX_DIV_FIRST_O[i*8 +: 8]  <= RX_DIV_FIRST_I;
          RX_DIV_SECOND_O[i*8 +: 8] <= RX_DIV_SECOND_I;
          RX_CRC_MF_O[i]      <= RX_CRC_MF_I;
          RX_CAS_O[i]         <= RX_CAS_I;
          RX_LINK_EN_O[i*3 +: 3] <= RX_LINK_EN_I;
          // out-of-range configuration codes are ignored
          if (RX_MODE_I < `E1FRD_RX_MODES)
            RX_MODE_O[i*`E1FRD_RX_MODE_W +: `E1FRD_RX_MODE_W] <= RX_MODE_I;
          RX_OUT_EN_O[i]      <= RX_OUT_EN_I;
          RX_SYS_FALL_O[i]    <= RX_SYS_FALL_I;
          RX_FS_MULTI_O[i]    <= RX_FS_MULTI_I;
          TX_SYS_FALL_O[i]    <= TX_SYS_FALL_I;
          if (TX_MODE_I <= `E1FRD_TX_MODES)
            TX_MODE_O[i*`E1FRD_TX_MODE_W +: `E1FRD_TX_MODE_W] <= TX_MODE_I;
          TX_CRC_MF_O[i]      <= TX_CRC_MF_I;
          TX_CAS_O[i]         <= TX_CAS_I;
          TX_LINK_EN_O[i*3 +: 3] <= TX_LINK_EN_I;
          TX_NRZ_O[i]         <= TX_NRZ_I;
          TX_UPDATE_RISE_O[i] <= TX_UPDATE_RISE_I;
          TX_DIV_FIRST_O[i*8 +: 8]  <= TX_DIV_FIRST_I;
          TX_DIV_SECOND_O[i*8 +: 8] <= TX_DIV_SECOND_I;
          TX_JAT_EN_O[i]      <= TX_JAT_EN_I;
          // pll smoothed clock only usable while attenuation is on
          TX_CLK_FROM_PLL_O[i] <= TX_JAT_EN_I;
        end
      end
    end
  end

endmodule

// [verif/e1frd_props.sv]
// e1frd_props.sv - port assertions for the framer reset/default block
// assumes one clock and an async active-low reset pin on e1frd_top
`timescale 1ns/1ps
module e1frd_props #(
  parameter N = 8
) (
  input wire logic         MCLK_I,
  input wire logic         RESETN_I,
  input wire logic         WR_I,
  input wire logic [2:0]   FRAMER_SEL_I,
  input wire logic         SOFT_RESET_I,
  input wire logic         STD_WR_I,
  input wire logic         STD_T1_I,
  input wire logic         CFG_WR_I,
  input wire logic         TX_CRC_MF_I,
  input wire logic         PATTERN_GEN_DETECTOR_WR_I,
  input wire logic [2:0]   PATTERN_GEN_DETECTOR_RX_SEL_I,
  input wire logic         LINE_STANDARD_SELECT_O,
  input wire logic [N-1:0] FRAMER_IN_RESET_O,
  input wire logic [N-1:0] TX_CRC_MF_O,
  input wire logic [N-1:0] TX_CLK_FROM_PLL_O,
  input wire logic [2:0]   PATTERN_GEN_DETECTOR_RX_SEL_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence soft_wr_s;
    (WR_I && SOFT_RESET_I) ##1 1'b1;
  endsequence
  soft_pulse_a: assert property (WR_I && SOFT_RESET_I |=>
    FRAMER_IN_RESET_O == (N'(1) << $past(FRAMER_SEL_I))) else $error("no pulse");
  pulse_clear_a: assert property (!(WR_I && SOFT_RESET_I) |=>
    FRAMER_IN_RESET_O == '0) else $error("stray reset pulse");
  soft_default_a: assert property (soft_wr_s |->
    !TX_CRC_MF_O[$past(FRAMER_SEL_I)] && TX_CLK_FROM_PLL_O[$past(FRAMER_SEL_I)])
    else $error("row not at defaults");
  cfg_write_a: assert property (CFG_WR_I && !SOFT_RESET_I |=>
    TX_CRC_MF_O[$past(FRAMER_SEL_I)] == $past(TX_CRC_MF_I)) else $error("cfg lost");
  std_write_a: assert property (STD_WR_I |=>
    LINE_STANDARD_SELECT_O == $past(STD_T1_I)) else $error("standard bit");
  std_hold_a: assert property (!STD_WR_I |=>
    $stable(LINE_STANDARD_SELECT_O)) else $error("standard bit moved");
  pattern_gen_detector_write_a: assert property (PATTERN_GEN_DETECTOR_WR_I |=>
    PATTERN_GEN_DETECTOR_RX_SEL_O == $past(PATTERN_GEN_DETECTOR_RX_SEL_I)) else $error("pattern select");
  pattern_gen_detector_keep_a: assert property (!PATTERN_GEN_DETECTOR_WR_I |=>
    $stable(PATTERN_GEN_DETECTOR_RX_SEL_O)) else $error("pattern select moved");
endmodule
bind e1frd_top e1frd_props #(.N(N)) chk (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I),
  .WR_I(WR_I), .FRAMER_SEL_I(FRAMER_SEL_I), .SOFT_RESET_I(SOFT_RESET_I),
  .STD_WR_I(STD_WR_I), .STD_T1_I(STD_T1_I), .CFG_WR_I(CFG_WR_I),
  .TX_CRC_MF_I(TX_CRC_MF_I), .PATTERN_GEN_DETECTOR_WR_I(PATTERN_GEN_DETECTOR_WR_I),
  .PATTERN_GEN_DETECTOR_RX_SEL_I(PATTERN_GEN_DETECTOR_RX_SEL_I), .LINE_STANDARD_SELECT_O(LINE_STANDARD_SELECT_O),
  .FRAMER_IN_RESET_O(FRAMER_IN_RESET_O), .TX_CRC_MF_O(TX_CRC_MF_O),
  .TX_CLK_FROM_PLL_O(TX_CLK_FROM_PLL_O), .PATTERN_GEN_DETECTOR_RX_SEL_O(PATTERN_GEN_DETECTOR_RX_SEL_O));

// [verif/e1frd_rst_src.sv]
// e1frd_rst_src.sv - system reset source driving the active-low pin
// assumes the bench clock; low at time zero, and again on each go pulse
`timescale 1ns/1ps
module e1frd_rst_src #(
  parameter HOLD = 20
) (
  input  wire logic clk_i,
  input  wire logic go_i,
  output logic      rstn_o
);
  int cnt = HOLD;
  initial rstn_o = 1'b0;
  // released just after an edge so release never races the sampling edge
  always @(posedge clk_i) begin
    if (go_i) begin
      rstn_o <= #1 1'b0;
      cnt    <= HOLD;
    end else if (cnt != 0) begin
      cnt    <= cnt - 1;
      rstn_o <= #1 (cnt == 1);
    end
  end
endmodule

// [verif/tb_e1frd_top.sv]
// tb_e1frd_top.sv - self-checking bench for the framer reset/default block
// assumes e1frd_top with eight framers, the reset source and the checker
`timescale 1ns/1ps
module tb_e1frd_top;
  localparam [56:0] DFLT = {2'b10, 8'h2F, 8'h2F, 2'b11, 3'h0, 3'h1, 4'h0,
                            2'h1, 2'b01, 3'h0, 2'b10, 8'h2F, 8'h2F, 2'b11};
  logic MCLK_I = 1'b0, wr, srst, stdwr, std, cfgwr, prgdwr, go;
  logic [2:0] sel, prx, ptx;
  logic [56:0] cfg, e;
  logic [56:0] exp [8];
  logic [31:0] seed = 32'h484D7A68;
  wire RESETN_I;
  int n_fail = 0, num_checks = 0, cyc = 0, i;
  always #2.5 MCLK_I = ~MCLK_I;
  e1frd_rst_src src (.clk_i(MCLK_I), .go_i(go), .rstn_o(RESETN_I));
  e1frd_top uut (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .WR_I(wr),
    .FRAMER_SEL_I(sel), .SOFT_RESET_I(srst), .STD_WR_I(stdwr), .STD_T1_I(std),
    .CFG_WR_I(cfgwr), .RX_NRZ_I(cfg[56]), .RX_SAMPLE_FALL_I(cfg[55]),
    .RX_DIV_FIRST_I(cfg[54:47]), .RX_DIV_SECOND_I(cfg[46:39]),
    .RX_CRC_MF_I(cfg[38]), .RX_CAS_I(cfg[37]), .RX_LINK_EN_I(cfg[36:34]),
    .RX_MODE_I(cfg[33:31]), .RX_OUT_EN_I(cfg[30]), .RX_SYS_FALL_I(cfg[29]),
    .RX_FS_MULTI_I(cfg[28]), .TX_SYS_FALL_I(cfg[27]), .TX_MODE_I(cfg[26:25]),
    .TX_CRC_MF_I(cfg[24]), .TX_CAS_I(cfg[23]), .TX_LINK_EN_I(cfg[22:20]),
    .TX_NRZ_I(cfg[19]), .TX_UPDATE_RISE_I(cfg[18]), .TX_DIV_FIRST_I(cfg[17:10]),
    .TX_DIV_SECOND_I(cfg[9:2]), .TX_JAT_EN_I(cfg[1]), .PATTERN_GEN_DETECTOR_WR_I(prgdwr),
    .PATTERN_GEN_DETECTOR_RX_SEL_I(prx), .PATTERN_GEN_DETECTOR_TX_SEL_I(ptx), .LINE_STANDARD_SELECT_O(),
    .FRAMER_IN_RESET_O(), .RX_NRZ_O(), .RX_SAMPLE_FALL_O(), .RX_DIV_FIRST_O(),
    .RX_DIV_SECOND_O(), .RX_CRC_MF_O(), .RX_CAS_O(), .RX_LINK_EN_O(),
    .RX_MODE_O(), .RX_OUT_EN_O(), .RX_SYS_FALL_O(), .RX_FS_MULTI_O(),
    .TX_SYS_FALL_O(), .TX_MODE_O(), .TX_CRC_MF_O(), .TX_CAS_O(),
    .TX_LINK_EN_O(), .TX_NRZ_O(), .TX_UPDATE_RISE_O(), .TX_DIV_FIRST_O(),
    .TX_DIV_SECOND_O(), .TX_JAT_EN_O(), .TX_CLK_FROM_PLL_O(),
    .PATTERN_GEN_DETECTOR_RX_SEL_O(), .PATTERN_GEN_DETECTOR_TX_SEL_O());
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [56:0] row(input int k);
    return {uut.RX_NRZ_O[k], uut.RX_SAMPLE_FALL_O[k], uut.RX_DIV_FIRST_O[k*8+:8],
      uut.RX_DIV_SECOND_O[k*8+:8], uut.RX_CRC_MF_O[k], uut.RX_CAS_O[k],
      uut.RX_LINK_EN_O[k*3+:3], uut.RX_MODE_O[k*3+:3], uut.RX_OUT_EN_O[k],
      uut.RX_SYS_FALL_O[k], uut.RX_FS_MULTI_O[k], uut.TX_SYS_FALL_O[k],
      uut.TX_MODE_O[k*2+:2], uut.TX_CRC_MF_O[k], uut.TX_CAS_O[k],
      uut.TX_LINK_EN_O[k*3+:3], uut.TX_NRZ_O[k], uut.TX_UPDATE_RISE_O[k],
      uut.TX_DIV_FIRST_O[k*8+:8], uut.TX_DIV_SECOND_O[k*8+:8],
      uut.TX_JAT_EN_O[k], uut.TX_CLK_FROM_PLL_O[k]};
  endfunction
  task automatic chk(input logic [56:0] got, input logic [56:0] want);
    num_checks++;
    if (got !== want) begin
      n_fail++;
      $display("FAIL %0t got %h want %h", $time, got, want);
    end
  endtask
  task step();
    @(posedge MCLK_I);
    #1;
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk_defaults();
    chk(57'(uut.LINE_STANDARD_SELECT_O), 57'h1);
    chk(57'({uut.PATTERN_GEN_DETECTOR_RX_SEL_O, uut.PATTERN_GEN_DETECTOR_TX_SEL_O}), '0);
    for (int k = 0; k < 8; k++) begin
      chk(row(k), DFLT);
      exp[k] = DFLT;
    end
  endtask
  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    {wr, srst, stdwr, std, cfgwr, prgdwr, go, sel, prx, ptx} = '0;
    cfg = '0;
    repeat (22) step();
    chk_defaults();
    std = 1'b0;
    stdwr = 1'b1;
    step();
    stdwr = 1'b0;
    chk(57'(uut.LINE_STANDARD_SELECT_O), '0);
    cfgwr = 1'b1;
    for (i = 0; i < 40; i++) begin
      sel = rnd();
      cfg = 57'({rnd(), rnd()});
      cfg[26:25] = i[1:0];
      cfg[33:31] = (i > 36) ? 3'(i - 32) : 3'(i % 5);
      e = {cfg[56:1], cfg[1]};
      if (i > 36) e[33:31] = exp[sel][33:31];
      step();
      chk(row(sel), e);
      exp[sel] = e;
    end
    {wr, srst, sel} = {2'b11, 3'h5};
    step();
    chk(row(5), DFLT);
    chk(57'(uut.FRAMER_IN_RESET_O), 57'h20);
    exp[5] = DFLT;
    {wr, cfgwr} = 2'b00;
    step();
    chk(57'(uut.FRAMER_IN_RESET_O), '0);
    chk(57'(uut.LINE_STANDARD_SELECT_O), '0);
    for (i = 0; i < 8; i++) chk(row(i), exp[i]);
    {prx, ptx, prgdwr} = {3'h6, 3'h3, 1'b1};
    step();
    prgdwr = 1'b0;
    chk(57'({uut.PATTERN_GEN_DETECTOR_RX_SEL_O, uut.PATTERN_GEN_DETECTOR_TX_SEL_O}), 57'h33);
    go = 1'b1;
    step();
    go = 1'b0;
    repeat (21) step();
    chk_defaults();
    final_report();
  end
endmodule
